// ### hdl/tsr_pkg.sv
// Shared constants and helpers for the temperature sensor readout link.
// Assumes a single 100 MHz clock shared by both ends of the link.
package tsr_pkg;

	// ==========================================
	// Addressing and commands
	localparam logic [5:0] ADDR_HI = 6'h20;
	localparam logic [7:0] CMD_RESET = 8'hfe;
	localparam logic [7:0] CMD_CONV_HOLD = 8'he3;
	localparam logic [7:0] CMD_CONV_POLL = 8'hf3;

	// ==========================================
	// Checksum
	localparam logic [7:0] CRC_POLY = 8'h31;
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam logic [1:0] LAST_BYTE_IDX = 2'h2;

	// ==========================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int CONV_TIME_MS = 43;
	localparam int CONV_CYCLES = CONV_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int SCL_PERIOD_NS = 2500;
	localparam int SCL_QTR_CYCLES = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================
	// Temperature scaling in hundredths of a degree
	localparam int TEMP_SPAN_CDEG = 17572;
	localparam int TEMP_OFFSET_CDEG = 4685;

	function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			if (c[7]) begin
				c = {c[6:0], 1'b0} ^ CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction

endpackage

// ### hdl/tsr_link_if.sv
// Two-wire link between the sensor end and the controller end.
// Both lines are open drain with a pull-up; a released line reads high.
`timescale 1ns/1ps
`default_nettype none

interface tsr_link_if;
	logic host_scl_o, host_scl_oe, host_sda_o, host_sda_oe;
	logic dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe;
	logic scl;
	logic sda;

	// ==========================================
	// Wired-AND resolution
	assign scl = !((host_scl_oe && !host_scl_o) || (dev_scl_oe && !dev_scl_o));
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

	modport dev (
		input scl, sda,
		output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe
	);

	modport host (
		input scl, sda,
		output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe
	);
endinterface

`default_nettype wire

// ### hdl/tsr_sensor.sv
// Sensor end: bus target, command decoder, conversion timer and result shifter.
// Assumes link lines are synchronous to clk and the controller runs far below clk.
`timescale 1ns/1ps
`default_nettype none

module tsr_sensor #(
	parameter logic ADDR_LSB = 1'b0,
	parameter int CONV_LEN = tsr_pkg::CONV_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [15:0] raw_temperature_code,
	output logic conv_busy,
	output logic result_valid,
	tsr_link_if.dev link
);

	typedef enum logic [2:0] {
		D_IDLE = 3'h0,
		D_ADDR = 3'h1,
		D_AACK = 3'h2,
		D_CMD = 3'h3,
		D_CACK = 3'h4,
		D_TX = 3'h5,
		D_TACK = 3'h6,
		D_WAIT = 3'h7
	} tsr_dev_state_t;

	tsr_dev_state_t state_reg;
	logic scl_q_reg, sda_q_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_reg;
	logic [1:0] byte_idx_reg;
	logic rw_reg;
	logic host_ack_reg;
	logic sda_oe_reg, scl_oe_reg;
	logic busy_reg, hold_reg, valid_reg;
	logic [31:0] conv_cnt_reg;
	logic [15:0] result_reg;
	logic [7:0] crc_reg;

	logic scl_rise, scl_fall, start_seen, stop_seen;
	logic byte_end, addr_ok, cmd_strobe;
	logic [7:0] first_byte, next_byte;

	// ==========================================
	// Bus event detection
	assign scl_rise = link.scl && !scl_q_reg;
	assign scl_fall = !link.scl && scl_q_reg;
	assign start_seen = scl_q_reg && link.scl && sda_q_reg && !link.sda;
	assign stop_seen = scl_q_reg && link.scl && !sda_q_reg && link.sda;
	assign byte_end = scl_fall && (bit_cnt_reg == 4'h8);

	assign addr_ok = (shift_reg[7:1] == {tsr_pkg::ADDR_HI, ADDR_LSB}) &&
		(!shift_reg[0] || (!busy_reg && valid_reg));

	assign cmd_strobe = (state_reg == D_CMD) && byte_end;

	function automatic logic [7:0] read_byte(input logic [1:0] idx, input logic [15:0] res,
		input logic [7:0] crc);
		case (idx)
			2'h0: read_byte = res[15:8];
			2'h1: read_byte = res[7:0];
			default: read_byte = crc;
		endcase
	endfunction

	assign first_byte = read_byte(2'h0, result_reg, crc_reg);
	assign next_byte = read_byte(byte_idx_reg + 2'h1, result_reg, crc_reg);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
		end else begin
			scl_q_reg <= link.scl;
			sda_q_reg <= link.sda;
		end
	end

	// ==========================================
	// Target protocol engine
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= D_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			byte_idx_reg <= 2'h0;
			rw_reg <= 1'b0;
			host_ack_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else if (start_seen) begin
			// A repeated start restarts addressing from any state
			state_reg <= D_ADDR;
			bit_cnt_reg <= 4'h0;
			sda_oe_reg <= 1'b0;
		end else if (stop_seen) begin
			state_reg <= D_IDLE;
			sda_oe_reg <= 1'b0;
		end else begin
			case (state_reg)
				D_ADDR, D_CMD: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], link.sda};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (byte_end) begin
						bit_cnt_reg <= 4'h0;
						if (state_reg == D_CMD) begin
							sda_oe_reg <= 1'b1;
							state_reg <= D_CACK;
						end else if (addr_ok) begin
							sda_oe_reg <= 1'b1;
							rw_reg <= shift_reg[0];
							state_reg <= D_AACK;
						end else begin
							state_reg <= D_WAIT;
						end
					end
				end
				D_AACK: begin
					if (scl_fall) begin
						if (rw_reg) begin
							tx_reg <= {first_byte[6:0], 1'b0};
							sda_oe_reg <= !first_byte[7];
							byte_idx_reg <= 2'h0;
							bit_cnt_reg <= 4'h1;
							state_reg <= D_TX;
						end else begin
							sda_oe_reg <= 1'b0;
							state_reg <= D_CMD;
						end
					end
				end
				D_CACK: begin
					if (scl_fall) begin
						sda_oe_reg <= 1'b0;
						state_reg <= D_WAIT;
					end
				end
				D_TX: begin
					if (byte_end) begin
						sda_oe_reg <= 1'b0;
						state_reg <= D_TACK;
					end else if (scl_fall) begin
						sda_oe_reg <= !tx_reg[7];
						tx_reg <= {tx_reg[6:0], 1'b0};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
				end
				D_TACK: begin
					if (scl_rise) begin
						host_ack_reg <= !link.sda;
					end else if (scl_fall) begin
						if (host_ack_reg && (byte_idx_reg != tsr_pkg::LAST_BYTE_IDX)) begin
							tx_reg <= {next_byte[6:0], 1'b0};
							sda_oe_reg <= !next_byte[7];
							byte_idx_reg <= byte_idx_reg + 2'h1;
							bit_cnt_reg <= 4'h1;
							state_reg <= D_TX;
						end else begin
							state_reg <= D_WAIT;
						end
					end
				end
				D_IDLE, D_WAIT: begin
					sda_oe_reg <= 1'b0;
				end
				default: begin
					state_reg <= D_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// Command execution and conversion timer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_reg <= 1'b0;
			hold_reg <= 1'b0;
			valid_reg <= 1'b0;
			conv_cnt_reg <= 32'h0;
			result_reg <= 16'h0000;
			crc_reg <= tsr_pkg::CRC_INIT;
		end else if (cmd_strobe && (shift_reg == tsr_pkg::CMD_RESET)) begin
			busy_reg <= 1'b0;
			hold_reg <= 1'b0;
			valid_reg <= 1'b0;
			conv_cnt_reg <= 32'h0;
		end else if (cmd_strobe && !busy_reg &&
			((shift_reg == tsr_pkg::CMD_CONV_HOLD) || (shift_reg == tsr_pkg::CMD_CONV_POLL))) begin
			busy_reg <= 1'b1;
			valid_reg <= 1'b0;
			hold_reg <= (shift_reg == tsr_pkg::CMD_CONV_HOLD);
			conv_cnt_reg <= 32'h0;
		end else if (busy_reg) begin
			if (conv_cnt_reg == 32'(CONV_LEN - 1)) begin
				busy_reg <= 1'b0;
				valid_reg <= 1'b1;
				result_reg <= raw_temperature_code;
				crc_reg <= tsr_pkg::crc8_byte(tsr_pkg::crc8_byte(tsr_pkg::CRC_INIT,
					raw_temperature_code[15:8]), raw_temperature_code[7:0]);
			end else begin
				conv_cnt_reg <= conv_cnt_reg + 32'h1;
			end
		end
	end

	// ==========================================
	// Clock stretching
	// Held only from the fall after the command ack, so no bit is cut short.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_oe_reg <= 1'b0;
		end else if (!busy_reg) begin
			scl_oe_reg <= 1'b0;
		end else if ((state_reg == D_CACK) && scl_fall && hold_reg) begin
			scl_oe_reg <= 1'b1;
		end
	end

	assign link.dev_sda_o = 1'b0;
	assign link.dev_scl_o = 1'b0;
	assign link.dev_sda_oe = sda_oe_reg;
	assign link.dev_scl_oe = scl_oe_reg;
	assign conv_busy = busy_reg;
	assign result_valid = valid_reg;

endmodule

`default_nettype wire

// ### hdl/tsr_host.sv
// Controller end: command port, bit engine, sequencer and result FIFO.
// Assumes the sensor end shares clk; link lines are resolved by the interface.
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Result FIFO, depth a power of two
module tsr_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
	logic [AW:0] count_reg, count_next;
	logic in_ready_reg, out_valid_reg, push, pop;

	assign push = in_valid && in_ready_reg;
	assign pop = out_valid_reg && out_ready;
	assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			in_ready_reg <= 1'b0;
			out_valid_reg <= 1'b0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			count_reg <= count_next;
			in_ready_reg <= (count_next != (AW+1)'(DEPTH));
			out_valid_reg <= (count_next != '0);
		end
	end

	assign in_ready = in_ready_reg;
	assign out_valid = out_valid_reg;
	assign out_data = mem[rd_ptr_reg];
endmodule

module tsr_host #(
	parameter logic ADDR_LSB = 1'b0,
	parameter int QTR_LEN = tsr_pkg::SCL_QTR_CYCLES,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	output logic cmd_ready,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [15:0] rd_raw,
	output logic [15:0] rd_cdeg,
	output logic rd_crc_ok,
	tsr_link_if.host link
);
	typedef enum logic [1:0] {E_IDLE = 2'h0, E_START = 2'h1, E_BIT = 2'h2, E_STOP = 2'h3} tsr_eng_t;
	typedef enum logic [3:0] {
		Q_IDLE = 4'h0, Q_RECOV = 4'h1, Q_RSTOP = 4'h2, Q_START = 4'h3,
		Q_ADDRW = 4'h4, Q_CMD = 4'h5, Q_STOP = 4'h6, Q_PSTART = 4'h7,
		Q_ADDRR = 4'h8, Q_PSTOP = 4'h9, Q_RD0 = 4'ha, Q_RD1 = 4'hb,
		Q_RD2 = 4'hc, Q_FSTOP = 4'hd, Q_PUSH = 4'he, Q_ASTOP = 4'hf
	} tsr_seq_t;

	tsr_eng_t eng_reg, op_sel;
	tsr_seq_t q_reg, q_next;
	logic [1:0] ph_reg;
	logic [7:0] qtr_reg;
	logic [3:0] bit_reg;
	logic [8:0] sh_reg, rx_reg, byte_sel;
	logic scl_oe_reg, sda_oe_reg, done_reg, go_reg, issued_reg, push_reg, ready_reg;
	logic [7:0] cmd_reg, hi_reg, lo_reg, chk_reg;
	logic tick, adv, accept, fifo_in_ready;
	logic [31:0] prod;
	logic [32:0] fifo_in;

	// ==========================================
	// Bit engine, quarter-period phases
	assign tick = (qtr_reg == 8'(QTR_LEN - 1));
	// Phase 1 waits for the clock to read high, which honours stretching
	assign adv = tick && !((ph_reg == 2'h1) && !link.scl);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			eng_reg <= E_IDLE;
			ph_reg <= 2'h0;
			qtr_reg <= 8'h00;
			bit_reg <= 4'h0;
			sh_reg <= 9'h1ff;
			rx_reg <= 9'h000;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			qtr_reg <= (eng_reg == E_IDLE || tick) ? 8'h00 : qtr_reg + 8'h01;
			if (eng_reg == E_IDLE) begin
				if (go_reg) begin
					eng_reg <= op_sel;
					ph_reg <= 2'h0;
					bit_reg <= 4'h0;
					sh_reg <= byte_sel;
					sda_oe_reg <= (op_sel == E_STOP) || ((op_sel == E_BIT) && !byte_sel[8]);
				end
			end else if (adv) begin
				ph_reg <= ph_reg + 2'h1;
				case (ph_reg)
					2'h0: scl_oe_reg <= 1'b0;
					2'h1: begin
						if (eng_reg == E_BIT) begin
							rx_reg <= {rx_reg[7:0], link.sda};
						end else begin
							sda_oe_reg <= (eng_reg == E_START);
						end
					end
					2'h2: begin
						scl_oe_reg <= (eng_reg != E_STOP);
						if (eng_reg != E_BIT) begin
							eng_reg <= E_IDLE;
							done_reg <= 1'b1;
						end
					end
					default: begin
						if (bit_reg == 4'h8) begin
							sda_oe_reg <= 1'b0;
							eng_reg <= E_IDLE;
							done_reg <= 1'b1;
						end else begin
							sda_oe_reg <= !sh_reg[7];
							sh_reg <= {sh_reg[7:0], 1'b1};
							bit_reg <= bit_reg + 4'h1;
						end
					end
				endcase
			end
		end
	end

	// ==========================================
	// Transaction sequencer
	always_comb begin
		op_sel = E_BIT;
		byte_sel = 9'h1ff;
		q_next = Q_IDLE;
		case (q_reg)
			Q_RECOV: q_next = Q_RSTOP;
			Q_RSTOP: begin op_sel = E_STOP; q_next = Q_START; end
			Q_START: begin op_sel = E_START; q_next = Q_ADDRW; end
			// address then command
			// An address nack ends the frame, else a conversion would poll forever
			Q_ADDRW: begin
				byte_sel = {tsr_pkg::ADDR_HI, ADDR_LSB, 1'b0, 1'b1};
				q_next = rx_reg[0] ? Q_ASTOP : Q_CMD;
			end
			Q_CMD: begin byte_sel = {cmd_reg, 1'b1}; q_next = Q_STOP; end
			Q_STOP: begin
				op_sel = E_STOP;
				q_next = (cmd_reg == tsr_pkg::CMD_CONV_HOLD || cmd_reg == tsr_pkg::CMD_CONV_POLL) ? Q_PSTART : Q_IDLE;
			end
			Q_PSTART: begin op_sel = E_START; q_next = Q_ADDRR; end
			Q_ADDRR: begin byte_sel = {tsr_pkg::ADDR_HI, ADDR_LSB, 1'b1, 1'b1}; q_next = rx_reg[0] ? Q_PSTOP : Q_RD0; end
			Q_PSTOP: begin op_sel = E_STOP; q_next = Q_PSTART; end
			Q_RD0: begin byte_sel = 9'h1fe; q_next = Q_RD1; end
			Q_RD1: begin byte_sel = 9'h1fe; q_next = Q_RD2; end
			Q_RD2: q_next = Q_FSTOP;
			Q_FSTOP: begin op_sel = E_STOP; q_next = Q_PUSH; end
			Q_ASTOP: begin op_sel = E_STOP; q_next = Q_IDLE; end
			default: q_next = Q_IDLE;
		endcase
	end

	assign accept = cmd_valid && ready_reg;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q_reg <= Q_IDLE;
			go_reg <= 1'b0;
			issued_reg <= 1'b0;
			push_reg <= 1'b0;
			ready_reg <= 1'b0;
			cmd_reg <= 8'h00;
			hi_reg <= 8'h00;
			lo_reg <= 8'h00;
			chk_reg <= 8'h00;
		end else begin
			go_reg <= 1'b0;
			push_reg <= 1'b0;
			// A push in flight may take the last slot before the FIFO's ready falls
			ready_reg <= (q_reg == Q_IDLE) && !accept && !push_reg && fifo_in_ready;
			case (q_reg)
				Q_IDLE: begin
					if (accept) begin
						cmd_reg <= cmd_code;
						q_reg <= link.sda ? Q_START : Q_RECOV;
					end
				end
				Q_PUSH: begin
					push_reg <= 1'b1;
					q_reg <= Q_IDLE;
				end
				default: begin
					if (!issued_reg) begin
						go_reg <= 1'b1;
						issued_reg <= 1'b1;
					end else if (done_reg) begin
						issued_reg <= 1'b0;
						q_reg <= q_next;
						if (q_reg == Q_RD0) hi_reg <= rx_reg[8:1];
						if (q_reg == Q_RD1) lo_reg <= rx_reg[8:1];
						if (q_reg == Q_RD2) chk_reg <= rx_reg[8:1];
					end
				end
			endcase
		end
	end

	// ==========================================
	// Result check, scaling and buffering
	// raw times span over 2^16
	assign prod = {16'h0000, hi_reg, lo_reg} * 32'(tsr_pkg::TEMP_SPAN_CDEG);
	assign fifo_in = {(tsr_pkg::crc8_byte(tsr_pkg::crc8_byte(tsr_pkg::crc8_byte(tsr_pkg::CRC_INIT,
		hi_reg), lo_reg), chk_reg) == 8'h00), hi_reg, lo_reg,
		prod[31:16] - 16'(tsr_pkg::TEMP_OFFSET_CDEG)};

	tsr_fifo #(.WIDTH(33), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(push_reg),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data({rd_crc_ok, rd_raw, rd_cdeg})
	);

	assign cmd_ready = ready_reg;
	assign link.host_scl_o = 1'b0;
	assign link.host_sda_o = 1'b0;
	assign link.host_scl_oe = scl_oe_reg;
	assign link.host_sda_oe = sda_oe_reg;
endmodule

`default_nettype wire

// ### test/tsr_link_asserts.sv
// Checker for the two-wire link between the sensor end and the controller end.
// Assumes the link lines are sampled on clk and the link runs far below clk.
`timescale 1ns/1ps
`default_nettype none

module tsr_link_asserts #(
	parameter logic ADDR_LSB = 1'b0,
	parameter int CONV_LEN = 200
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_scl_oe,
	input wire logic dev_sda_oe
);
	logic scl_reg, sda_reg, frame_reg, rd_reg;
	logic [7:0] sh_reg, cmd_reg;
	logic [3:0] bit_reg;
	logic [1:0] byte_reg;
	int hold_reg, conv_reg;
	logic rise, start_ev, stop_ev, ack_ev;
	assign rise = scl && !scl_reg;
	assign start_ev = scl && scl_reg && sda_reg && !sda;
	assign stop_ev = scl && scl_reg && !sda_reg && sda;
	assign ack_ev = rise && bit_reg == 4'h8;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// ==========================================
	// Wire decoding
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
		end else begin
			scl_reg <= scl;
			sda_reg <= sda;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			frame_reg <= 1'b0;
		end else if (start_ev || stop_ev) begin
			frame_reg <= start_ev;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bit_reg <= 4'h0;
			byte_reg <= 2'h0;
			sh_reg <= 8'h00;
		end else if (start_ev) begin
			bit_reg <= 4'h0;
			byte_reg <= 2'h0;
		end else if (ack_ev) begin
			bit_reg <= 4'h0;
			byte_reg <= byte_reg + 2'h1;
		end else if (rise) begin
			bit_reg <= bit_reg + 4'h1;
			sh_reg <= {sh_reg[6:0], sda};
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_reg <= 1'b0;
			cmd_reg <= 8'h00;
		end else if (ack_ev && byte_reg == 2'h0) begin
			rd_reg <= sh_reg[0];
		end else if (ack_ev && byte_reg == 2'h1 && !rd_reg) begin
			cmd_reg <= sh_reg;
		end
	end
	// A sixteenth of the conversion covers the strobe-to-ack delay, since the strobe is not visible here
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			conv_reg <= 0;
		end else if (ack_ev && byte_reg == 2'h1 && !rd_reg) begin
			conv_reg <= (sh_reg == tsr_pkg::CMD_RESET) ? 0 : CONV_LEN - CONV_LEN / 16;
		end else if (conv_reg != 0) begin
			conv_reg <= conv_reg - 1;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_reg <= 0;
		end else begin
			hold_reg <= dev_scl_oe ? hold_reg + 1 : 0;
		end
	end

	// ==========================================
	// Properties
	start_order_a: assert property (start_ev |-> !frame_reg)
		else $error("start without a preceding stop");
	sda_change_a: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("sensor moved data while clock high");
	write_len_a: assert property (stop_ev && frame_reg && !rd_reg |-> byte_reg == 2'h2)
		else $error("write frame not two bytes");
	addr_ack_a: assert property (ack_ev && byte_reg == 2'h0 && !sh_reg[0]
		&& sh_reg[7:1] == {tsr_pkg::ADDR_HI, ADDR_LSB} |-> !sda)
		else $error("own write address not acked");
	poll_nack_a: assert property (ack_ev && byte_reg == 2'h0 && sh_reg[0] && conv_reg != 0 |-> sda)
		else $error("read acked during conversion");
	stretch_cmd_a: assert property ($rose(dev_scl_oe) |-> cmd_reg == tsr_pkg::CMD_CONV_HOLD)
		else $error("clock stretched without hold command");
	stretch_len_a: assert property (hold_reg <= CONV_LEN)
		else $error("stretch longer than conversion");
	stretch_min_a: assert property ($fell(dev_scl_oe) |-> $past(hold_reg) >= CONV_LEN / 2)
		else $error("stretch released early");
	nack_quiet_a: assert property (ack_ev && rd_reg && byte_reg != 2'h0 && sda |=> !dev_sda_oe [*8])
		else $error("sensor drove data after nack");
	read_len_a: assert property (ack_ev && rd_reg && byte_reg != 2'h0 |-> sda == (byte_reg == 2'h3))
		else $error("read not three bytes ended by nack");

	cover property (start_ev);
	cover property ($rose(dev_scl_oe));
	cover property (ack_ev && byte_reg == 2'h0 && sh_reg[0] && sda);
	cover property (ack_ev && rd_reg && byte_reg == 2'h3);
endmodule

`default_nettype wire

// ### test/tb_i2c_temperature_sensor_readout.sv
// Bench: sensor and controller ends on one link, plus a pair whose addresses disagree.
// Assumes 100 MHz clk; conversion and bit timing are shortened by parameters.
`timescale 1ns/1ps
`default_nettype none

module tb_i2c_temperature_sensor_readout;
	localparam int CONV = 200;
	localparam int QTR = 4;
	logic clk, rst_b, cmd_valid, rd_ready, cmd_valid_b, cmd_ready, rd_valid, rd_crc_ok;
	logic conv_busy, result_valid, cmd_ready_b, rd_valid_b, busy_b, stretch_seen, busy_b_seen, busy_seen, valid_b;
	logic [7:0] cmd_code;
	logic [15:0] raw_code, rd_raw, rd_cdeg;
	logic [31:0] seed;
	logic [15:0] exp_q[$];
	logic [7:0] wire_q[$];
	int err_count, n_tests;

	tsr_link_if link();
	tsr_link_if link_b();
	tsr_sensor #(.ADDR_LSB(1'b0), .CONV_LEN(CONV)) tsr_sensor_inst(.clk(clk), .rst_b(rst_b),
		.raw_temperature_code(raw_code), .conv_busy(conv_busy), .result_valid(result_valid), .link(link));
	tsr_host #(.ADDR_LSB(1'b0), .QTR_LEN(QTR), .FIFO_DEPTH(8)) tsr_host_inst(.clk(clk), .rst_b(rst_b),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready(cmd_ready), .rd_valid(rd_valid),
		.rd_ready(rd_ready), .rd_raw(rd_raw), .rd_cdeg(rd_cdeg), .rd_crc_ok(rd_crc_ok), .link(link));
	tsr_link_asserts #(.ADDR_LSB(1'b0), .CONV_LEN(CONV)) tsr_link_asserts_inst(.clk(clk), .rst_b(rst_b),
		.scl(link.scl), .sda(link.sda), .dev_scl_oe(link.dev_scl_oe), .dev_sda_oe(link.dev_sda_oe));
	// Second pair: the sensor answers another address, so it must stay silent
	tsr_sensor #(.ADDR_LSB(1'b1), .CONV_LEN(CONV)) tsr_sensor_inst_b(.clk(clk), .rst_b(rst_b),
		.raw_temperature_code(raw_code), .conv_busy(busy_b), .result_valid(valid_b), .link(link_b));
	tsr_host #(.ADDR_LSB(1'b0), .QTR_LEN(QTR), .FIFO_DEPTH(8)) tsr_host_inst_b(.clk(clk), .rst_b(rst_b),
		.cmd_valid(cmd_valid_b), .cmd_code(cmd_code), .cmd_ready(cmd_ready_b),
		.rd_valid(rd_valid_b), .rd_ready(rd_ready), .rd_raw(), .rd_cdeg(), .rd_crc_ok(), .link(link_b));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================
	// Expectations
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [7:0] exp_crc(input logic [15:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 15; i >= 0; i--) begin
			c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
		end
		return c;
	endfunction
	function automatic logic [15:0] exp_cdeg(input logic [15:0] r);
		logic [31:0] p;
		p = 32'(r) * 32'(tsr_pkg::TEMP_SPAN_CDEG);
		return p[31:16] - 16'(tsr_pkg::TEMP_OFFSET_CDEG);
	endfunction

	// ==========================================
	// Monitors and tasks
	always @(posedge clk) begin
		if (link.dev_scl_oe === 1'b1) stretch_seen <= 1'b1;
		if (busy_b === 1'b1) busy_b_seen <= 1'b1;
		if (conv_busy === 1'b1) busy_seen <= 1'b1;
		if (tsr_link_asserts_inst.ack_ev && tsr_link_asserts_inst.rd_reg && tsr_link_asserts_inst.byte_reg != 2'h0)
			wire_q.push_back(tsr_link_asserts_inst.sh_reg);
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic wait_ready(input int lim);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < lim) begin
			n++;
			@(posedge clk);
		end
	endtask
	task automatic send(input logic [7:0] c, input logic [15:0] r);
		@(posedge clk);
		wait_ready(20000);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		raw_code <= r;
		@(posedge clk);
		cmd_valid <= 1'b0;
	endtask
	task automatic pop();
		int n;
		logic [15:0] r;
		n = 0;
		r = exp_q.pop_front();
		@(posedge clk);
		while (rd_valid !== 1'b1 && n < 20000) begin
			n++;
			@(posedge clk);
		end
		check("raw", rd_raw, r);
		check("cdeg", rd_cdeg, exp_cdeg(r));
		check("crc_ok", rd_crc_ok, 1'b1);
		check("wire_hi", wire_q.pop_front(), r[15:8]);
		check("wire_lo", wire_q.pop_front(), r[7:0]);
		check("wire_crc", wire_q.pop_front(), exp_crc(r));
		rd_ready <= 1'b1;
		@(posedge clk);
		rd_ready <= 1'b0;
	endtask
	task automatic run_conv(input logic [7:0] m, input logic [15:0] r);
		stretch_seen <= 1'b0;
		busy_seen <= 1'b0;
		send(m, r);
		exp_q.push_back(r);
		pop();
		check("stretch", stretch_seen, m == tsr_pkg::CMD_CONV_HOLD);
		check("result_valid", result_valid, 1'b1);
		check("busy_seen", busy_seen, 1'b1);
	endtask

	// ==========================================
	// Main sequence
	initial begin
		rst_b = 1'b0;
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		raw_code = 16'h0000;
		rd_ready = 1'b0;
		cmd_valid_b = 1'b0;
		stretch_seen = 1'b0;
		busy_b_seen = 1'b0;
		busy_seen = 1'b0;
		seed = 32'he634;
		err_count = 0;
		n_tests = 0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		check("reset_ready", {cmd_ready, rd_valid, conv_busy, link.scl, link.sda}, 5'h03);
		$display("test reset done");
		run_conv(tsr_pkg::CMD_CONV_POLL, 16'h683a);
		run_conv(tsr_pkg::CMD_CONV_HOLD, 16'h0000);
		run_conv(tsr_pkg::CMD_CONV_POLL, 16'hffff);
		run_conv(tsr_pkg::CMD_CONV_HOLD, 16'h8000);
		for (int i = 0; i < 10; i++) begin
			seed = xs(seed);
			run_conv(seed[0] ? tsr_pkg::CMD_CONV_HOLD : tsr_pkg::CMD_CONV_POLL, seed[31:16]);
		end
		$display("test conversions done");
		send(tsr_pkg::CMD_RESET, 16'h1234);
		repeat (2) @(posedge clk);
		wait_ready(20000);
		check("reset_cmd", {result_valid, conv_busy, rd_valid}, 3'h0);
		$display("test reset command done");
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			send(seed[1] ? tsr_pkg::CMD_CONV_HOLD : tsr_pkg::CMD_CONV_POLL, seed[15:0]);
			exp_q.push_back(seed[15:0]);
		end
		repeat (2) @(posedge clk);
		wait_ready(3000);
		check("full_refuse", cmd_ready, 1'b0);
		repeat (8) pop();
		@(posedge clk);
		check("drained", rd_valid, 1'b0);
		wait_ready(100);
		check("ready_again", cmd_ready, 1'b1);
		$display("test buffer done");
		@(posedge clk);
		cmd_valid_b <= 1'b1;
		cmd_code <= tsr_pkg::CMD_CONV_POLL;
		@(posedge clk);
		while (cmd_ready_b !== 1'b1) @(posedge clk);
		cmd_valid_b <= 1'b0;
		repeat (2) @(posedge clk);
		while (cmd_ready_b !== 1'b1) @(posedge clk);
		check("other_addr", {busy_b_seen, rd_valid_b, valid_b}, 3'h0);
		$display("test address mismatch done");
		test_done();
	end

	initial begin
		#950000;
		err_count++;
		test_done();
	end
endmodule

`default_nettype wire
